// file: verilog/aocr_output_config.sv
// Purpose: output driver configuration bank with master and active copies
// Assumes: serial port logic already decodes address, data and write strobe
// Notes:   all settings act only after a transfer write to the update register
//
// What this block does
// - format register bit 6 picks standard or reduced-swing low-power driver
// - format register bit 2 set inverts output data, clear passes it
// - format bits 1:0 pick offset binary (00) or two's complement (01)
// - termination bits 5:4: 00 none, 01 higher value, 10/11 lower value
// - phase bits 3:0 choose divider phase for output clock, 0000 to 1010
// - each phase code adds sixty degrees, code ten gives six hundred
// - after reset the output clock sits at one hundred eighty degrees
// - phase choice touches only the output clock, never data latching
// - pattern one low byte holds bits 7:0, resets to zero
// - format and termination registers both reset to zero
// - pattern one high byte holds bits 15:8, resets to zero
// - user-input test mode drives pattern bits 7:0, coded by the format bits, instead of samples
// - written values reach active copies only on a software transfer
`default_nettype none

module aocr_output_config
  import aocr_pkg::*;
(
  input  wire logic                     sys_clk,      // 20 MHz sample-domain clock
  input  wire logic                     resetn,       // async reset, active low
  input  wire logic [7:0]               regAddr,      // register offset
  input  wire logic                     regWrEn,      // one-cycle write strobe
  input  wire logic [REG_W-1:0]         regWrData,    // write data
  input  wire logic                     regRdEn,      // one-cycle read strobe
  output logic      [REG_W-1:0]         regRdData,    // read data, one cycle later
  input  wire logic [NUM_CH-1:0]        chanSelect,   // channels taking writes
  input  wire logic [3:0]               testModeSel,  // output test mode code
  input  wire logic [NUM_CH*DATA_W-1:0] sampleIn,     // converted words per channel
  output logic      [NUM_CH*DATA_W-1:0] dataOut,      // coded words per channel
  output logic      [NUM_CH-1:0]        drvLowPower,  // reduced-swing driver select
  output logic      [NUM_CH*2-1:0]      termCode,     // termination code per channel
  output logic      [3:0]               clkPhaseSel,  // output clock divider phase
  output logic      [DEG_W-1:0]         clkPhaseDeg   // output clock offset, degrees
);

  // ****************************************
  // state
  // ****************************************
  logic [NUM_CH-1:0][REG_W-1:0] fmtMst_reg, fmtMst_next;
  logic [NUM_CH-1:0][REG_W-1:0] termMst_reg, termMst_next;
  logic [NUM_CH-1:0][REG_W-1:0] fmtAct_reg, fmtAct_next;
  logic [NUM_CH-1:0][REG_W-1:0] termAct_reg, termAct_next;
  logic [3:0]                   phaseMst_reg, phaseMst_next;
  logic [3:0]                   phaseAct_reg, phaseAct_next;
  logic [REG_W-1:0]             pattLoMst_reg, pattLoMst_next;
  logic [REG_W-1:0]             pattHiMst_reg, pattHiMst_next;
  logic [2*REG_W-1:0]           pattAct_reg, pattAct_next;
  logic [REG_W-1:0]             rdData_reg, rdData_next;
  logic [NUM_CH*DATA_W-1:0]     dataOut_reg, dataOut_next;
  logic                         xferPulse;
  logic [1:0]                   readCh;

  // ****************************************
  // write decode and master copies
  // ****************************************
  // a transfer is a write of one to the update bit; it never stores anything
  assign xferPulse = regWrEn && (regAddr == ADDR_XFER) && regWrData[XFER_BIT];

  // per-channel masters only change for channels selected at write time
  always_comb
  begin
    fmtMst_next    = fmtMst_reg;
    termMst_next   = termMst_reg;
    phaseMst_next  = phaseMst_reg;
    pattLoMst_next = pattLoMst_reg;
    pattHiMst_next = pattHiMst_reg;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (regWrEn && chanSelect[c] && (regAddr == ADDR_DRV_FORMAT))
      begin
        fmtMst_next[c] = regWrData & FORMAT_MASK;
      end
      else if (regWrEn && chanSelect[c] && (regAddr == ADDR_DRV_TERM))
      begin
        termMst_next[c] = regWrData & TERM_MASK;
      end
    end
    // out-of-range phase codes are dropped so the clock never leaves 0..600 deg
    if (regWrEn && (regAddr == ADDR_CLK_PHASE) &&
        (regWrData[PHASE_LSB +: 4] <= PHASE_MAX))
    begin
      phaseMst_next = regWrData[PHASE_LSB +: 4];
    end
    if (regWrEn && (regAddr == ADDR_PATT1_LOW))
    begin
      pattLoMst_next = regWrData;
    end
    if (regWrEn && (regAddr == ADDR_PATT1_HIGH))
    begin
      pattHiMst_next = regWrData;
    end
  end

  // ****************************************
  // active copies
  // ****************************************
  // everything moves together; dataOut takes the new setup one cycle after the other outputs
  always_comb
  begin
    fmtAct_next   = fmtAct_reg;
    termAct_next  = termAct_reg;
    phaseAct_next = phaseAct_reg;
    pattAct_next  = pattAct_reg;
    if (xferPulse)
    begin
      fmtAct_next   = fmtMst_reg;
      termAct_next  = termMst_reg;
      phaseAct_next = phaseMst_reg;
      pattAct_next  = {pattHiMst_reg, pattLoMst_reg};
    end
  end

  // ****************************************
  // read back
  // ****************************************
  // per-channel registers read from the lowest selected channel
  always_comb
  begin
    readCh = 2'h0;
    for (int c = NUM_CH - 1; c >= 0; c--)
    begin
      if (chanSelect[c])
      begin
        readCh = c[1:0];
      end
    end
  end

  always_comb
  begin
    rdData_next = rdData_reg;
    if (regRdEn)
    begin
      if (regAddr == ADDR_DRV_FORMAT)
      begin
        rdData_next = fmtMst_reg[readCh];
      end
      else if (regAddr == ADDR_DRV_TERM)
      begin
        rdData_next = termMst_reg[readCh];
      end
      else if (regAddr == ADDR_CLK_PHASE)
      begin
        rdData_next = {4'h0, phaseMst_reg};
      end
      else if (regAddr == ADDR_PATT1_LOW)
      begin
        rdData_next = pattLoMst_reg;
      end
      else if (regAddr == ADDR_PATT1_HIGH)
      begin
        rdData_next = pattHiMst_reg;
      end
      else
      begin
        rdData_next = 8'h00;                        // unmapped and update read zero
      end
    end
  end

  // ****************************************
  // data path per channel
  // ****************************************
  // the phase setting is not used here, so data timing stays fixed
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : gen_ch
      logic [DATA_W-1:0] word;
      always_comb
      begin
        word = sampleIn[g*DATA_W +: DATA_W];
        if (testModeSel == TEST_USER)
        begin
          word = pattAct_reg[DATA_W-1:0];
        end
        if (fmtAct_reg[g][FMT_LSB +: 2] == FMT_TWOS)
        begin
          word[DATA_W-1] = ~word[DATA_W-1];
        end
        if (fmtAct_reg[g][INVERT_BIT])
        begin
          word = ~word;
        end
      end
      // one continuous driver per slice, so no two processes share dataOut_next
      assign dataOut_next[g*DATA_W +: DATA_W] = word;
      assign drvLowPower[g]      = fmtAct_reg[g][LOW_POWER_BIT];
      assign termCode[g*2 +: 2]  = termAct_reg[g][TERM_LSB +: 2];

      AST_INVERT_APPLIED: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fmtAct_reg[g][INVERT_BIT] && fmtAct_reg[g][FMT_LSB +: 2] == FMT_OFFSET &&
         testModeSel != TEST_USER)
        |=> dataOut[g*DATA_W +: DATA_W] == ~$past(sampleIn[g*DATA_W +: DATA_W]))
        else $error("inverted data does not match sample");
      AST_TWOS_MSB: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!fmtAct_reg[g][INVERT_BIT] && fmtAct_reg[g][FMT_LSB +: 2] == FMT_TWOS &&
         testModeSel != TEST_USER)
        |=> dataOut[g*DATA_W+DATA_W-1] == ~$past(sampleIn[g*DATA_W+DATA_W-1]))
        else $error("two's complement sign bit wrong");
      AST_FMT_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$past(xferPulse) |-> $stable(fmtAct_reg[g]))
        else $error("active format changed without transfer");
      AST_SELECT_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
        (regWrEn && regAddr == ADDR_DRV_TERM && chanSelect[g])
        |=> termMst_reg[g] == ($past(regWrData) & TERM_MASK))
        else $error("selected channel missed termination write");
      AST_UNSELECTED_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn)
        (regWrEn && regAddr == ADDR_DRV_FORMAT && !chanSelect[g])
        |=> $stable(fmtMst_reg[g]))
        else $error("unselected channel took format write");
    end
  endgenerate

  // ****************************************
  // clock phase outputs
  // ****************************************
  assign clkPhaseSel = phaseAct_reg;
  assign clkPhaseDeg = DEG_STEP * DEG_W'(phaseAct_reg);
  assign dataOut     = dataOut_reg;
  assign regRdData   = rdData_reg;

  // ****************************************
  // registers
  // ****************************************
  // pattern and format masters clear so a first transfer is harmless
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        fmtMst_reg[c]  <= FORMAT_RST;
        termMst_reg[c] <= TERM_RST;
        fmtAct_reg[c]  <= FORMAT_RST;
        termAct_reg[c] <= TERM_RST;
      end
      phaseMst_reg  <= PHASE_RST;
      phaseAct_reg  <= PHASE_RST;
      pattLoMst_reg <= PATT_RST;
      pattHiMst_reg <= PATT_RST;
      pattAct_reg   <= {PATT_RST, PATT_RST};
      rdData_reg    <= 8'h00;
      dataOut_reg   <= '0;
    end
    else
    begin
      fmtMst_reg    <= fmtMst_next;
      termMst_reg   <= termMst_next;
      fmtAct_reg    <= fmtAct_next;
      termAct_reg   <= termAct_next;
      phaseMst_reg  <= phaseMst_next;
      phaseAct_reg  <= phaseAct_next;
      pattLoMst_reg <= pattLoMst_next;
      pattHiMst_reg <= pattHiMst_next;
      pattAct_reg   <= pattAct_next;
      rdData_reg    <= rdData_next;
      dataOut_reg   <= dataOut_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence phaseWrite;
    regWrEn && regAddr == ADDR_CLK_PHASE && regWrData[PHASE_LSB +: 4] <= PHASE_MAX;
  endsequence

  sequence phaseXfer;
    regWrEn && regAddr == ADDR_XFER && regWrData[XFER_BIT];
  endsequence

  AST_PHASE_PATH: assert property (@(posedge sys_clk) disable iff (!resetn)
    phaseWrite ##1 (!regWrEn)[*1] ##1 phaseXfer
    |=> clkPhaseSel == $past(regWrData[PHASE_LSB +: 4], 3))
    else $error("phase did not follow write then transfer");
  AST_PHASE_DEG: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkPhaseDeg == {clkPhaseSel, 6'h00} - {4'h0, clkPhaseSel, 2'h0} &&
    clkPhaseSel <= PHASE_MAX)
    else $error("phase degrees out of step");
  AST_PHASE_RESET: assert property (@(posedge sys_clk)
    $rose(resetn) |-> clkPhaseSel == PHASE_RST && clkPhaseDeg == 10'h0b4)
    else $error("output clock not at 180 degrees after reset");
  AST_USER_PATTERN: assert property (@(posedge sys_clk) disable iff (!resetn)
    (testModeSel == TEST_USER && fmtAct_reg[0] == FORMAT_RST)
    |=> dataOut[DATA_W-1:0] == $past(pattAct_reg[DATA_W-1:0]))
    else $error("user pattern not on outputs");
  AST_PATT_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regRdEn && regAddr == ADDR_PATT1_HIGH) |=> regRdData == $past(pattHiMst_reg))
    else $error("pattern high byte read wrong");
  AST_LOWPOWER_OUT: assert property (@(posedge sys_clk) disable iff (!resetn)
    $past(xferPulse) |-> drvLowPower[0] == $past(fmtMst_reg[0][LOW_POWER_BIT]))
    else $error("low-power select not applied");
  AST_TERM_OUT: assert property (@(posedge sys_clk) disable iff (!resetn)
    $past(xferPulse) |-> termCode[1:0] == $past(termMst_reg[0][TERM_LSB +: 2]))
    else $error("termination code not applied");
  AST_PATT_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regWrEn && regAddr == ADDR_PATT1_LOW) ##2 phaseXfer
    |=> pattAct_reg[DATA_W-1:0] == $past(regWrData, 3))
    else $error("pattern low byte not transferred");

endmodule : aocr_output_config

`default_nettype wire

// file: include/aocr_pkg.sv
// Purpose: shared constants for the converter output configuration bank
// Assumes: 8-bit register port, four data channels
// Notes:   offsets are byte addresses on the serial control port
`default_nettype none

package aocr_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int NUM_CH    = 4;
  localparam int DATA_W    = 8;
  localparam int REG_W     = 8;
  localparam int DEG_W     = 10;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_DRV_FORMAT  = 8'h14;
  localparam logic [7:0] ADDR_DRV_TERM    = 8'h15;
  localparam logic [7:0] ADDR_CLK_PHASE   = 8'h16;
  localparam logic [7:0] ADDR_PATT1_LOW   = 8'h19;
  localparam logic [7:0] ADDR_PATT1_HIGH  = 8'h1a;
  localparam logic [7:0] ADDR_XFER        = 8'hff;

  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int LOW_POWER_BIT = 6;
  localparam int INVERT_BIT    = 2;
  localparam int FMT_LSB       = 0;
  localparam int TERM_LSB      = 4;
  localparam int PHASE_LSB     = 0;
  localparam int XFER_BIT      = 0;
  localparam logic [7:0] FORMAT_MASK = 8'h47;
  localparam logic [7:0] TERM_MASK   = 8'h30;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] FORMAT_RST  = 8'h00;
  localparam logic [7:0] TERM_RST    = 8'h00;
  localparam logic [7:0] PATT_RST    = 8'h00;
  localparam logic [3:0] PHASE_RST   = 4'h3;
  localparam logic [3:0] PHASE_MAX   = 4'ha;
  localparam logic [1:0] FMT_OFFSET  = 2'h0;
  localparam logic [1:0] FMT_TWOS    = 2'h1;
  localparam logic [3:0] TEST_USER   = 4'h8;
  localparam logic [DEG_W-1:0] DEG_STEP = 10'h03c;

endpackage : aocr_pkg

`default_nettype wire

// file: sim/aocr_host_model.sv
// Purpose: serial port host model that writes and reads the output config bank
// Assumes: one-cycle strobes, read data valid after the taking edge
// Notes:   released write data shows the inverse of the last value
`default_nettype none

module aocr_host_model
  import aocr_pkg::*;
(
  input  wire logic             sys_clk,    // bus clock
  output logic      [7:0]       regAddr,    // register offset
  output logic                  regWrEn,    // write strobe
  output logic      [REG_W-1:0] regWrData,  // write data
  output logic                  regRdEn,    // read strobe
  input  wire logic [REG_W-1:0] regRdData   // read data
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end

  // ****************************************
  // bus cycles
  // ****************************************
  // one write; an edge always passes with the strobe low before the next
  task automatic wr(input logic [7:0] a, input logic [REG_W-1:0] d);
    @(posedge sys_clk);
    #1;
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(posedge sys_clk);
    #1;
    regWrEn   = 1'b0;
    regWrData = ~d;  // no stale value on a released bus
  endtask

  // one read; data is taken once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [REG_W-1:0] d);
    @(posedge sys_clk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge sys_clk);
    #1;
    regRdEn = 1'b0;
    d       = regRdData;
  endtask

  // settings only act once the host asks for the transfer
  task automatic xfer();
    wr(ADDR_XFER, 8'h01);
  endtask
endmodule // aocr_host_model

`default_nettype wire

// file: sim/testbench.sv
// Purpose: self-checking bench for the output configuration bank
// Assumes: host model drives the register port, bench drives the rest
// Notes:   each scenario is a task that judges its own results
`default_nettype none

module testbench
  import aocr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk, resetn;
  logic [7:0] regAddr, regWrData, regRdData, rv;
  logic regWrEn, regRdEn;
  logic [NUM_CH-1:0] chanSelect, drvLowPower;
  logic [3:0] testModeSel, clkPhaseSel;
  logic [31:0] sampleIn, dataOut;
  logic [7:0] termCode;
  logic [DEG_W-1:0] clkPhaseDeg;
  int nErrors, totalChecks, cycles;

  aocr_output_config i_dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .chanSelect(chanSelect), .testModeSel(testModeSel), .sampleIn(sampleIn),
    .dataOut(dataOut), .drvLowPower(drvLowPower), .termCode(termCode),
    .clkPhaseSel(clkPhaseSel), .clkPhaseDeg(clkPhaseDeg));

  aocr_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  // 20 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // a hang counts as a mismatch and ends the run
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      nErrors++;
      testDone();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, rv);
    chk(nm, {24'h0, exp}, {24'h0, rv});
  endtask

  // transfer, then let the new setting reach dataOut
  task automatic xsettle();
    i_host.xfer();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // expected coding: two's complement flips the msb, then invert flips all
  function automatic logic [31:0] coded(input logic [7:0] f, input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int c = 0; c < 4; c++)
    begin
      if (f[1:0] == 2'h1) r[8*c+7] = ~r[8*c+7];
      if (f[2]) r[8*c+:8] = ~r[8*c+:8];
    end
    return r;
  endfunction

  task automatic testDone();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // while reset is held the read register stays cleared, so the phase reads zero
  task automatic t_reset(input bit held);
    chk("rst data", 32'h0, dataOut);
    chk("rst lowpower", 32'h0, {28'h0, drvLowPower});
    chk("rst term", 32'h0, {24'h0, termCode});
    chk("rst phase", 32'h3, {28'h0, clkPhaseSel});
    chk("rst deg", 32'd180, {22'h0, clkPhaseDeg});
    rdchk("rd fmt", ADDR_DRV_FORMAT, 8'h00);
    rdchk("rd term", ADDR_DRV_TERM, 8'h00);
    rdchk("rd phase", ADDR_CLK_PHASE, held ? 8'h00 : 8'h03);
    rdchk("rd patlo", ADDR_PATT1_LOW, 8'h00);
    rdchk("rd pathi", ADDR_PATT1_HIGH, 8'h00);
    rdchk("rd unmapped", 8'h30, 8'h00);
  endtask

  // format codes act only after transfer, on all selected channels
  task automatic t_format();
    logic [7:0] f[3] = '{8'h04, 8'h41, 8'h45};
    i_host.wr(ADDR_DRV_FORMAT, 8'h04);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("held data", sampleIn, dataOut);
    foreach (f[i])
    begin
      i_host.wr(ADDR_DRV_FORMAT, f[i]);
      rdchk("rd fmt", ADDR_DRV_FORMAT, f[i]);
      xsettle();
      chk("coded data", coded(f[i], sampleIn), dataOut);
      chk("lowpower", {28'h0, {4{f[i][6]}}}, {28'h0, drvLowPower});
    end
  endtask

  // every termination code on all four channels
  task automatic t_term();
    for (int c = 0; c < 4; c++)
    begin
      i_host.wr(ADDR_DRV_TERM, 8'(c << 4));
      xsettle();
      chk("term", {24'h0, {4{2'(c)}}}, {24'h0, termCode});
    end
  endtask

  // phase sweep, illegal code, data latency kept
  task automatic t_phase();
    for (int p = 0; p <= 10; p++)
    begin
      i_host.wr(ADDR_CLK_PHASE, 8'(p));
      xsettle();
      chk("phase", 32'(p), {28'h0, clkPhaseSel});
      chk("deg", 32'(p * 60), {22'h0, clkPhaseDeg});
      sampleIn = ~sampleIn;
      @(posedge sys_clk);
      #1;
      chk("latency", coded(8'h45, sampleIn), dataOut);
    end
    i_host.wr(ADDR_CLK_PHASE, 8'h0b);
    xsettle();
    chk("bad phase", 32'ha, {28'h0, clkPhaseSel});
  endtask

  // writes land only on selected channels; readback with a single channel selected
  task automatic t_chan();
    i_host.wr(ADDR_DRV_FORMAT, 8'h00);
    chanSelect = 4'b0101;
    i_host.wr(ADDR_DRV_FORMAT, 8'h40);
    i_host.wr(ADDR_DRV_TERM, 8'h10);
    xsettle();
    chk("chan lp", 32'h5, {28'h0, drvLowPower});
    chk("chan term", 32'hdd, {24'h0, termCode});
    chanSelect = 4'b0010;
    rdchk("rd chan b", ADDR_DRV_FORMAT, 8'h00);
    chanSelect = 4'hf;
    i_host.wr(ADDR_DRV_FORMAT, 8'h00);
  endtask

  // user pattern replaces samples once transferred
  task automatic t_pattern();
    i_host.wr(ADDR_PATT1_LOW, 8'ha5);
    i_host.wr(ADDR_PATT1_HIGH, 8'h3c);
    rdchk("rd patlo", ADDR_PATT1_LOW, 8'ha5);
    rdchk("rd pathi", ADDR_PATT1_HIGH, 8'h3c);
    testModeSel = TEST_USER;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("pattern held", 32'h0, dataOut);
    xsettle();
    chk("pattern", 32'ha5a5a5a5, dataOut);
    i_host.wr(ADDR_PATT1_LOW, 8'h5a);
    xsettle();
    chk("pattern low", 32'h5a5a5a5a, dataOut);
    testModeSel = 4'h0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    nErrors     = 0;
    totalChecks = 0;
    cycles      = 0;
    resetn      = 1'b0;
    chanSelect  = 4'hf;
    testModeSel = 4'h0;
    sampleIn    = 32'h817e00ff;
    repeat (10) @(posedge sys_clk);
    #1;
    t_reset(1'b1);
    resetn = 1'b1;
    t_reset(1'b0);
    t_format();
    t_term();
    t_phase();
    t_chan();
    t_pattern();
    testDone();
  end
endmodule // testbench

`default_nettype wire
